// [rtl/otp_lock_crc_register_guard.sv]
// OTP lock/CRC byte keeper, block and continuous CRC checker, register answers
//
// Functional notes
// - Lock byte written by hardware on burn
// - Lock bit7, identifier 6:4, CRC 3:0
// - Identifiers: mirror 000, blocks A-F 001-110
// - Unburned: lock zero, id and CRC zero
// - Reserved reads still answered validly
// - Reserved writes executed and answered; the code ignores them (a 0x1F write changes nothing) but still answers
// - Unmapped read answers 0x00
// - Unmapped write changes nothing, answers 0x00
// - Read-only write dropped, answers current contents
// - Factory blocks carry per-block 4-bit CRC
// - CRC x^4+x^3+1 from zero seed
// - MSB first, ascending addresses
// - User blocks E and F CRC checked
// - Mirrored region checked against its CRC
// - Mirror writable only before init done
// - Continuous CRC after init, skipping device lock
// - User data writable only before init done
`timescale 1ns/1ps
`include "otp_guard_map.svh"

module otp_lock_crc_register_guard #(
    // Factory blocks A..D, 15 data bytes each, block A byte 0 lowest
    parameter logic [479:0] FACTORY_IMG = '0,
    // Factory stored CRC per block, block A in bits 3:0
    parameter logic [15:0] FACTORY_CRC = 16'h0000
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic init_done,
    output logic engine_busy,
    output logic factory_crc_err,
    output logic user_crc_err,
    output logic cont_crc_err
);

    // Whole state and its next value
    otp_guard_pkg::guard_state_t s;
    otp_guard_pkg::guard_state_t s_nxt;

    // Decode of the current command
    logic dec_mapped;
    logic dec_wr_ok;
    logic [7:0] dec_rd;
    // Lock byte address of the block in work
    logic [7:0] cur_lock_addr;
    // Serial CRC engine controls
    logic crc_clear;
    logic crc_shift;
    logic crc_bit;
    logic [3:0] crc_val;

    // Upper address nibble of a block from its identifier
    function automatic logic [3:0] blk_hi(input logic [2:0] id);
        blk_hi = (id == `ID_MIRROR) ? `MIRROR_HI : 4'({1'b0, id} + `BLK_HI_OFS);
    endfunction

    // Only the mirror and user blocks E and F can be burned; factory blocks come preloaded
    function automatic logic burnable(input logic [2:0] id);
        burnable = (id == `ID_MIRROR) || (id == `ID_E) || (id == `ID_F);
    endfunction

    // Shared serial engine for boot, burn and continuous passes
    crc4_serial u_crc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(crc_clear),
        .shift_en(crc_shift),
        .bit_in(crc_bit),
        .crc(crc_val)
    );

    // Next-state logic: register access first, then the CRC sequencer
    always_comb begin
        logic [3:0] hi;
        logic [3:0] lo;
        logic [3:0] bhi;
        logic last_bit;
        hi = cmd_addr[7:4];
        lo = cmd_addr[3:0];
        bhi = blk_hi(s.blk_id);
        last_bit = (s.bit_idx == 3'h7) && (s.addr == s.last_addr);
        s_nxt = s;
        dec_mapped = 1'b1;
        dec_wr_ok = 1'b0;
        dec_rd = s.mem[cmd_addr];
        cur_lock_addr = {bhi, `LOCK_LO};
        crc_clear = 1'b0;
        crc_shift = 1'b0;
        crc_bit = s.mem[s.addr][3'h7 - s.bit_idx];

        // Address decode
        if (cmd_addr >= `RW_FIRST && cmd_addr <= `RW_LAST) begin
            dec_wr_ok = !s.init_done;
        end else if (cmd_addr == `BURN_REG) begin
            // Status view; reserved bit 3 reads zero
            dec_rd = {s.busy, s.fact_err, s.user_err, s.cont_err, 1'b0, s.burn_id};
        end else if (cmd_addr == `INIT_REG) begin
            dec_rd = {7'h00, s.init_done};
        end else if (cmd_addr == `DEVLOCK_REG) begin
            // Device lock stays writable, outside the continuous CRC
            dec_wr_ok = 1'b1;
        end else if (hi == `MIRROR_HI) begin
            dec_wr_ok = (lo != `LOCK_LO) && !s.init_done;
        end else if (hi >= `FACT_FIRST_HI) begin
            dec_wr_ok = (hi >= `USER_FIRST_HI) && (lo != `LOCK_LO) && !s.init_done
                && !s.mem[{hi, `LOCK_LO}][`LOCK_BIT];
        end else begin
            dec_mapped = 1'b0;
            dec_rd = 8'h00;
        end

        s_nxt.resp_valid = cmd_valid;
        if (cmd_valid) begin
            s_nxt.resp_data = (cmd_write && dec_wr_ok) ? cmd_wdata : dec_rd;
            if (cmd_write && dec_wr_ok) begin
                s_nxt.mem[cmd_addr] = cmd_wdata;
            end
            if (cmd_write && cmd_addr == `BURN_REG && cmd_wdata[`BURN_GO_BIT]
                && !s.burn_pend && !s.init_done && burnable(cmd_wdata[2:0])
                && !s.mem[{blk_hi(cmd_wdata[2:0]), `LOCK_LO}][`LOCK_BIT]) begin
                s_nxt.burn_pend = 1'b1;
                s_nxt.burn_id = cmd_wdata[2:0];
            end
            // Init flag only sets; reset is the sole way back
            if (cmd_write && cmd_addr == `INIT_REG && cmd_wdata[0]) begin
                s_nxt.init_done = 1'b1;
            end
        end

        // Sequencer
        case (s.fsm)
            otp_guard_pkg::ST_IDLE: begin
                if (s.boot_pend) begin
                    // Boot check of every burned block, skip the blank ones
                    s_nxt.job = otp_guard_pkg::JOB_BOOT;
                    s_nxt.blk_id = s.boot_idx;
                    if (s.mem[{blk_hi(s.boot_idx), `LOCK_LO}][`LOCK_BIT]) begin
                        crc_clear = 1'b1;
                        s_nxt.fsm = otp_guard_pkg::ST_SCAN;
                        s_nxt.addr = {blk_hi(s.boot_idx), 4'h0};
                        s_nxt.last_addr = {blk_hi(s.boot_idx), `DATA_LAST_LO};
                        s_nxt.bit_idx = 3'h0;
                    end else if (s.boot_idx == `ID_LAST) begin
                        s_nxt.boot_pend = 1'b0;
                    end else begin
                        s_nxt.boot_idx = s.boot_idx + 3'h1;
                    end
                end else if (s.burn_pend) begin
                    // Burn computes the CRC of the block data just written
                    crc_clear = 1'b1;
                    s_nxt.job = otp_guard_pkg::JOB_BURN;
                    s_nxt.blk_id = s.burn_id;
                    s_nxt.fsm = otp_guard_pkg::ST_SCAN;
                    s_nxt.addr = {blk_hi(s.burn_id), 4'h0};
                    s_nxt.last_addr = {blk_hi(s.burn_id), `DATA_LAST_LO};
                    s_nxt.bit_idx = 3'h0;
                end else if (s.init_done) begin
                    crc_clear = 1'b1;
                    s_nxt.job = otp_guard_pkg::JOB_CONT;
                    s_nxt.fsm = otp_guard_pkg::ST_SCAN;
                    s_nxt.addr = `RW_FIRST;
                    s_nxt.last_addr = `MIRROR_DATA_LAST;
                    s_nxt.bit_idx = 3'h0;
                end
            end
            otp_guard_pkg::ST_SCAN: begin
                crc_shift = 1'b1;
                s_nxt.bit_idx = s.bit_idx + 3'h1;
                if (s.bit_idx == 3'h7) begin
                    // jump over command and lock registers
                    s_nxt.addr = (s.addr == `RW_LAST) ? `MIRROR_FIRST : s.addr + 8'h01;
                end
                if (last_bit) begin
                    s_nxt.fsm = otp_guard_pkg::ST_FINISH;
                end
            end
            otp_guard_pkg::ST_FINISH: begin
                s_nxt.fsm = otp_guard_pkg::ST_IDLE;
                if (s.job == otp_guard_pkg::JOB_BURN) begin
                    s_nxt.mem[cur_lock_addr] = {1'b1, s.blk_id, crc_val};
                    s_nxt.burn_pend = 1'b0;
                end else if (s.job == otp_guard_pkg::JOB_BOOT) begin
                    if (crc_val != s.mem[cur_lock_addr][`CRC_MSB:0]) begin
                        if (s.blk_id != `ID_MIRROR && s.blk_id <= `ID_FACT_LAST) begin
                            s_nxt.fact_err = 1'b1;
                        end else begin
                            s_nxt.user_err = 1'b1;
                        end
                    end
                    if (s.boot_idx == `ID_LAST) begin
                        s_nxt.boot_pend = 1'b0;
                    end else begin
                        s_nxt.boot_idx = s.boot_idx + 3'h1;
                    end
                end else begin
                    if (!s.ref_ok) begin
                        s_nxt.cont_ref = crc_val;
                        s_nxt.ref_ok = 1'b1;
                    end else if (crc_val != s.cont_ref) begin
                        s_nxt.cont_err = 1'b1;
                    end
                end
            end
            default: begin
                s_nxt.fsm = otp_guard_pkg::ST_IDLE;
            end
        endcase
        s_nxt.busy = (s_nxt.fsm != otp_guard_pkg::ST_IDLE);
    end

    // State register; factory blocks come up burned with their stored CRC
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.fsm <= otp_guard_pkg::ST_IDLE;
            s.job <= otp_guard_pkg::JOB_BOOT;
            s.boot_pend <= 1'b1;
            for (int b = 0; b < 4; b++) begin
                for (int k = 0; k < 15; k++) begin
                    s.mem[{`FACT_FIRST_HI + 4'(b), 4'(k)}] <= FACTORY_IMG[(b * 15 + k) * 8 +: 8];
                end
                s.mem[{`FACT_FIRST_HI + 4'(b), `LOCK_LO}] <=
                    {1'b1, 3'(b + 1), FACTORY_CRC[b * 4 +: 4]};
            end
        end else begin
            s <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign resp_valid = s.resp_valid;
    assign resp_data = s.resp_data;
    assign init_done = s.init_done;
    assign engine_busy = s.busy;
    assign factory_crc_err = s.fact_err;
    assign user_crc_err = s.user_err;
    assign cont_crc_err = s.cont_err;

    // Checks on the design's own behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // A burn pass reaching its end
    sequence burn_end_s;
        s.fsm == otp_guard_pkg::ST_FINISH && s.job == otp_guard_pkg::JOB_BURN;
    endsequence

    // Continuous pass end with no boot work left
    sequence cont_end_s;
        s.fsm == otp_guard_pkg::ST_FINISH && s.job == otp_guard_pkg::JOB_CONT && !s.boot_pend;
    endsequence

    // Back to idle and starting a fresh continuous pass
    sequence cont_restart_s;
        s.fsm == otp_guard_pkg::ST_IDLE ##1
            (s.fsm == otp_guard_pkg::ST_SCAN && s.addr == `RW_FIRST && s.bit_idx == 3'h0);
    endsequence

    resp_every_cmd_a: assert property (cmd_valid |=> resp_valid)
        else $error("command not answered next cycle");

    unmapped_read_zero_a: assert property (
        cmd_valid && !cmd_write && !dec_mapped |=> resp_valid && resp_data == 8'h00)
        else $error("unmapped read not zero");

    unmapped_write_inert_a: assert property (
        cmd_valid && cmd_write && !dec_mapped && s.fsm != otp_guard_pkg::ST_FINISH
        |=> resp_data == 8'h00 && s.mem == $past(s.mem))
        else $error("unmapped write had effect");

    ro_write_echo_a: assert property (
        cmd_valid && cmd_write && cmd_addr >= 8'hA0 && !dec_wr_ok
        |=> resp_data == $past(dec_rd))
        else $error("read-only write answer wrong");

    burn_lock_pack_a: assert property (
        burn_end_s |=> s.mem[$past(cur_lock_addr)] == {1'b1, $past(s.blk_id), $past(crc_val)})
        else $error("lock byte not packed after burn");

    burn_retire_a: assert property (
        burn_end_s |=> s.fsm == otp_guard_pkg::ST_IDLE && !s.burn_pend)
        else $error("burn request not retired");

    block_e_id_a: assert property (
        s.mem[`USER_E_LOCK_ADDR][`LOCK_BIT] |-> s.mem[`USER_E_LOCK_ADDR][6:4] == `ID_E)
        else $error("block E identifier wrong");

    mirror_frozen_a: assert property (
        s.init_done |=> $stable(s.mem[`MIRROR_DATA_LAST:`MIRROR_FIRST]))
        else $error("mirror changed after init");

    crc_seed_a: assert property (crc_clear |=> crc_val == `CRC_SEED)
        else $error("crc not seeded with zero");

    scan_bit_step_a: assert property (
        s.fsm == otp_guard_pkg::ST_SCAN && s.bit_idx != 3'h7
        |=> s.fsm == otp_guard_pkg::ST_SCAN && s.bit_idx == 3'($past(s.bit_idx) + 3'h1))
        else $error("scan did not advance one bit");

    cont_restart_a: assert property (cont_end_s |=> cont_restart_s)
        else $error("continuous pass did not restart");

endmodule

// [rtl/otp_guard_map.svh]
// Register offsets, field positions and CRC constants of the OTP lock/CRC guard
`ifndef OTP_GUARD_MAP_SVH
`define OTP_GUARD_MAP_SVH

// Lock/CRC byte of each 16-byte block
`define MIRROR_LOCK_ADDR 8'h5F
`define FACT_A_LOCK_ADDR 8'hAF
`define FACT_B_LOCK_ADDR 8'hBF
`define FACT_C_LOCK_ADDR 8'hCF
`define FACT_D_LOCK_ADDR 8'hDF
`define USER_E_LOCK_ADDR 8'hEF
`define USER_F_LOCK_ADDR 8'hFF

// Block layout: upper nibble picks block, low nibble F is the lock byte
`define MIRROR_HI 4'h5
`define FACT_FIRST_HI 4'hA
`define USER_FIRST_HI 4'hE
`define BLK_HI_OFS 4'h9
`define LOCK_LO 4'hF
`define DATA_LAST_LO 4'hE
`define MIRROR_FIRST 8'h50
`define MIRROR_DATA_LAST 8'h5E

// Lock byte fields
`define LOCK_BIT 7
`define ID_MSB 6
`define ID_LSB 4
`define CRC_MSB 3

// Block identifiers
`define ID_MIRROR 3'h0
`define ID_FACT_LAST 3'h4
`define ID_E 3'h5
`define ID_F 3'h6
`define ID_LAST 3'h6

// Read/write array, burn command, init flag and device lock registers
`define RW_FIRST 8'h10
`define RW_LAST 8'h1B
`define BURN_REG 8'h1C
`define INIT_REG 8'h1D
`define DEVLOCK_REG 8'h1E
`define BURN_GO_BIT 7

// CRC x^4 + x^3 + 1 and its seed
`define CRC_POLY 4'h9
`define CRC_SEED 4'h0

`endif

// [rtl/otp_guard_pkg.sv]
// Types shared by the OTP lock/CRC guard and its serial CRC engine
package otp_guard_pkg;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SCAN = 3'h2,
        ST_FINISH = 3'h4
    } fsm_t;

    // Kind of pass the sequencer runs, one-hot
    typedef enum logic [2:0] {
        JOB_BOOT = 3'h1,
        JOB_BURN = 3'h2,
        JOB_CONT = 3'h4
    } job_t;

    // Serial CRC engine state
    typedef struct packed {
        logic [3:0] crc_r;
    } crc_state_t;

    // Guard state
    typedef struct packed {
        fsm_t fsm;
        job_t job;
        logic [255:0][7:0] mem;
        logic boot_pend;
        logic [2:0] boot_idx;
        logic burn_pend;
        logic [2:0] burn_id;
        logic [2:0] blk_id;
        logic [7:0] addr;
        logic [7:0] last_addr;
        logic [2:0] bit_idx;
        logic [3:0] cont_ref;
        logic ref_ok;
        logic init_done;
        logic fact_err;
        logic user_err;
        logic cont_err;
        logic resp_valid;
        logic [7:0] resp_data;
        logic busy;
    } guard_state_t;

endpackage

// [rtl/crc4_serial.sv]
// Serial four-bit CRC shift register, one message bit per clock
`timescale 1ns/1ps
`include "otp_guard_map.svh"

module crc4_serial (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic shift_en,
    input wire logic bit_in,
    output logic [3:0] crc
);

    // Register and its next value
    otp_guard_pkg::crc_state_t s;
    otp_guard_pkg::crc_state_t s_nxt;

    // Clear wins over shift so a new pass always starts at the seed
    always_comb begin
        s_nxt = s;
        if (clear) begin
            s_nxt.crc_r = `CRC_SEED;
        end else if (shift_en) begin
            // Outgoing MSB folded with the new bit drives the taps
            s_nxt.crc_r = {s.crc_r[2:0], 1'b0} ^ ((s.crc_r[3] ^ bit_in) ? `CRC_POLY : 4'h0);
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= s_nxt;
        end
    end

    assign crc = s.crc_r;

endmodule

// [test/host_model.sv]
// Host controller model that issues single-byte register commands
`timescale 1ns/1ps

module host_model (
    input wire logic ref_clk,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_addr,
    output logic [7:0] cmd_wdata
);
    // Idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 8'h00;
        cmd_wdata = 8'h00;
    end

    // One command, answer sampled once the answer edge has settled
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= a;
        // reserved bits zero
        // Callers hand over data with reserved bits already cleared
        cmd_wdata <= d;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        // Released qualifiers flip so stale values never look valid
        cmd_write <= ~wr;
        cmd_addr <= ~a;
        cmd_wdata <= ~d;
        #1;
        ok = resp_valid;
        q = resp_data;
    endtask
endmodule

// [test/test_otp_lock_crc_register_guard.sv]
// Self-checking bench for the OTP lock/CRC guard through its command port
`timescale 1ns/1ps

module test_otp_lock_crc_register_guard;
    // Reference CRC over 15 bytes, byte 0 lowest, MSB first
    function automatic logic [3:0] crc_blk(input logic [119:0] b);
        logic [3:0] c;
        logic fb;
        c = 4'h0;
        for (int i = 0; i < 15; i++) begin
            for (int j = 7; j >= 0; j--) begin
                fb = c[3] ^ b[i*8+j];
                c = {c[2:0], 1'b0} ^ (fb ? 4'h9 : 4'h0);
            end
        end
        return c;
    endfunction

    // Block A holds one nonzero byte so its stored CRC is not trivial
    localparam logic [3:0] CRC_A = crc_blk(120'h01);
    localparam logic [3:0] CRC_M = crc_blk(120'h0FC3);
    localparam logic [3:0] CRC_E = crc_blk(120'h5A);

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid, cmd_write, resp_valid, init_done, engine_busy;
    logic factory_crc_err, user_crc_err, cont_crc_err;
    logic [7:0] cmd_addr, cmd_wdata, resp_data;
    int err_total = 0;
    int total_checks = 0;

    // Free-running 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    otp_lock_crc_register_guard #(.FACTORY_IMG(480'h1), .FACTORY_CRC({12'h000, CRC_A})) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
        .resp_data(resp_data), .init_done(init_done), .engine_busy(engine_busy),
        .factory_crc_err(factory_crc_err), .user_crc_err(user_crc_err),
        .cont_crc_err(cont_crc_err));

    host_model host (
        .ref_clk(ref_clk), .resp_valid(resp_valid), .resp_data(resp_data),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata));

    // Single comparison point, four-state exact
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Read and write with a checked answer
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic ok;
        host.access(1'b0, a, 8'h00, q, ok);
        check("read answer strobe", {7'h00, ok}, 8'h01);
        check($sformatf("read of %h", a), q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] q;
        logic ok;
        host.access(1'b1, a, d, q, ok);
        check("write answer strobe", {7'h00, ok}, 8'h01);
        check($sformatf("write answer of %h", a), q, exp);
    endtask

    // Bounded wait for the sequencer to go quiet
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(posedge ref_clk);
        // Look a little after the edge so the flag has settled
        #1;
        while (engine_busy !== 1'b0 && n < 600) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("sequencer idle", {7'h00, engine_busy}, 8'h00);
    endtask

    task automatic do_reset();
        // Reset changes only on a clock edge, like every other input
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Boot check covers four factory blocks of about 122 cycles each
        repeat (800) @(posedge ref_clk);
        wait_idle();
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 2900 cycles
    initial begin
        #(8 * 20000);
        err_total++;
        wrap_up();
    end

    // Main sequence
    initial begin
        do_reset();
        check("factory error", {7'h00, factory_crc_err}, 8'h00);
        check("user error", {7'h00, user_crc_err}, 8'h00);
        check("init flag", {7'h00, init_done}, 8'h00);
        rd(8'hAF, {4'h9, CRC_A});
        rd(8'hA0, 8'h01);
        rd(8'hBF, 8'hA0);
        rd(8'hCF, 8'hB0);
        rd(8'hDF, 8'hC0);
        rd(8'h5F, 8'h00);
        rd(8'hEF, 8'h00);
        rd(8'hFF, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h30, 8'h55, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h1F, 8'h77, 8'h00);
        rd(8'h1F, 8'h00);
        wr(8'hAF, 8'h55, {4'h9, CRC_A});
        wr(8'hA0, 8'hFF, 8'h01);
        rd(8'hAF, {4'h9, CRC_A});
        rd(8'h1D, 8'h00);
        wr(8'h10, 8'hA5, 8'hA5);
        rd(8'h10, 8'hA5);
        wr(8'h50, 8'hC3, 8'hC3);
        wr(8'h51, 8'h0F, 8'h0F);
        wr(8'hE0, 8'h5A, 8'h5A);
        rd(8'hE0, 8'h5A);
        // Command writes answer with the status as it stood before the write
        wr(8'h1C, 8'h80, 8'h00);
        wait_idle();
        rd(8'h5F, {4'h8, CRC_M});
        wr(8'h1C, 8'h85, 8'h00);
        wait_idle();
        rd(8'hEF, {4'hD, CRC_E});
        wr(8'h1C, 8'h86, 8'h05);
        wait_idle();
        rd(8'h1C, 8'h06);
        rd(8'hFF, 8'hE0);
        rd(8'h5F, {4'h8, CRC_M});
        wr(8'hE0, 8'h00, 8'h5A);
        check("user error after burns", {7'h00, user_crc_err}, 8'h00);
        wr(8'h1D, 8'h01, 8'h00);
        check("init flag set", {7'h00, init_done}, 8'h01);
        wr(8'h50, 8'h00, 8'hC3);
        wr(8'h10, 8'h00, 8'hA5);
        wr(8'h1E, 8'h3C, 8'h3C);
        repeat (300) @(posedge ref_clk);
        wr(8'h1E, 8'hC3, 8'hC3);
        repeat (500) @(posedge ref_clk);
        check("continuous error", {7'h00, cont_crc_err}, 8'h00);
        rd(8'h1D, 8'h01);
        // Second reset mid-run wipes user state back to unprogrammed
        do_reset();
        check("init flag after reset", {7'h00, init_done}, 8'h00);
        rd(8'h5F, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'hAF, {4'h9, CRC_A});
        wrap_up();
    end
endmodule
